// File: cmpo_pkg.sv
// constants of the compare-match output unit
// assumes a single 40 MHz clock and a 32-bit AXI4-Lite register bus
package cmpo_pkg;

    localparam int CMPO_CLK_KHZ = 40000;
    localparam int CMPO_TICK_US = 100;
    localparam int CMPO_TICK_CYCLES = (CMPO_TICK_US * CMPO_CLK_KHZ + 999) / 1000;

    localparam int CMPO_AW = 8;

    localparam logic [7:0] CMPO_OFF_CTRL = 8'h00;
    localparam logic [7:0] CMPO_OFF_CHANNEL = 8'h04;
    localparam logic [7:0] CMPO_OFF_THRESH_LO = 8'h08;
    localparam logic [7:0] CMPO_OFF_THRESH_HI = 8'h0c;
    localparam logic [7:0] CMPO_OFF_HOLD = 8'h10;
    localparam logic [7:0] CMPO_OFF_STATUS = 8'h14;
    localparam logic [7:0] CMPO_OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] CMPO_OFF_IRQ_MASK = 8'h1c;

    localparam int CMPO_CTRL_EXEC_BIT = 0;
    localparam int CMPO_CTRL_ABORT_BIT = 1;

    localparam int CMPO_ST_DONE_BIT = 0;
    localparam int CMPO_ST_BUSY_BIT = 1;
    localparam int CMPO_ST_ABORTED_BIT = 2;
    localparam int CMPO_ST_ERROR_BIT = 3;
    localparam int CMPO_ST_CODE_LSB = 16;

    localparam int CMPO_IRQ_DONE_BIT = 0;
    localparam int CMPO_IRQ_ABORTED_BIT = 1;
    localparam int CMPO_IRQ_ERROR_BIT = 2;

    localparam logic [7:0] CMPO_CHANNEL_RST = 8'h01;
    localparam logic [7:0] CMPO_CHANNEL_MAX = 8'h02;
    localparam logic [63:0] CMPO_THRESH_RST = 64'h0000_0000_0000_0000;
    localparam logic [31:0] CMPO_HOLD_RST = 32'h0000_03e8;

    localparam logic [1:0] CMPO_RESP_OKAY = 2'b00;
    localparam logic [1:0] CMPO_RESP_SLVERR = 2'b10;

    typedef enum logic [15:0] {
        CMPO_FAULT_NONE = 16'h0000,
        CMPO_FAULT_COMM = 16'h0001,
        CMPO_FAULT_DO_CFG = 16'h0030,
        CMPO_FAULT_PARAM = 16'h1004
    } cmpo_fault_t;

endpackage

// File: cmpo_reg_if.sv
// register access carrier from the bus slave to the register file
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface cmpo_reg_if;
    import cmpo_pkg::*;
    logic wr_en;
    logic [CMPO_AW-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [CMPO_AW-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;

    modport bus (
        output wr_en,
        output wr_addr,
        output wr_data,
        output wr_strb,
        output rd_addr,
        input wr_hit,
        input rd_data,
        input rd_hit
    );
    modport regs (
        input wr_en,
        input wr_addr,
        input wr_data,
        input wr_strb,
        input rd_addr,
        output wr_hit,
        output rd_data,
        output rd_hit
    );
endinterface

// File: cmpo_axil.sv
// AXI4-Lite slave front end: one write and one read in flight at a time
// assumes the register file answers in the same cycle
`timescale 1ns/1ps
module cmpo_axil
    import cmpo_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [CMPO_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [CMPO_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    cmpo_reg_if.bus rif
);
    logic aw_full_q;
    logic w_full_q;
    logic [CMPO_AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // address and data stay latched until the response is taken
    assign rif.wr_en = aw_full_q && w_full_q && !s_axi_bvalid;
    assign rif.wr_addr = awaddr_q;
    assign rif.wr_data = wdata_q;
    assign rif.wr_strb = wstrb_q;
    assign rif.rd_addr = s_axi_araddr;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CMPO_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (rif.wr_en) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= rif.wr_hit ? CMPO_RESP_OKAY : CMPO_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= CMPO_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rif.rd_hit ? rif.rd_data : 32'h0000_0000;
            s_axi_rresp <= rif.rd_hit ? CMPO_RESP_OKAY : CMPO_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// File: cmpo_hold.sv
// output hold timer: counts whole 100 us ticks from a clock divider
// assumes start is a one-cycle pulse and units is non-zero
`timescale 1ns/1ps
module cmpo_hold
    import cmpo_pkg::*;
#(
    parameter int TICK_CYCLES = CMPO_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic stop,
    input wire logic [31:0] units,
    output logic expired
);
    localparam int DW = $clog2(TICK_CYCLES + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);

    if (TICK_CYCLES < 1) begin
        $error("tick length must be at least one cycle");
    end

    logic run_q;
    logic [DW-1:0] div_q;
    logic [31:0] left_q;
    logic tick;

    // divider restarts with each job so the first tick is a whole one
    assign tick = run_q && (div_q == DIV_LAST);
    assign expired = tick && (left_q == 32'h0000_0001);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= 1'b0;
            div_q <= '0;
            left_q <= 32'h0000_0000;
        end else begin
            if (stop) begin
                run_q <= 1'b0;
            end else if (start) begin
                run_q <= 1'b1;
                div_q <= '0;
                left_q <= units;
            end else if (run_q) begin
                div_q <= tick ? '0 : div_q + 1'b1;
                if (tick) begin
                    left_q <= left_q - 32'h0000_0001;
                end
                if (expired) begin
                    run_q <= 1'b0;
                end
            end
        end
    end
endmodule

// File: cmpo_compare_output_block.sv
// Function
// RULE1: start only on execute rising edge
// RULE2: abort level stops running job
// RULE3: abort acknowledged raised after abort
// RULE4: channel 1 or 2, default 1
// RULE5: float threshold, default zero, compared
// RULE6: hold in 100 us units, default 1000
// RULE7: match drives port for hold time
// RULE8: done only after match and hold
// RULE9: one match per start, then rearm
// RULE10: internal fault raises error output
// RULE11: fault code none until fault occurs
// RULE12: unconfigured output terminal gives 0x30
// RULE13: invalid channel parameters give 0x1004
// RULE14: counter communication failure gives 0x01
// RULE15: busy until exactly one terminal report
//
// compare-match output unit with AXI4-Lite registers and one interrupt
// assumes the counter-side inputs come from same-clock logic
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module cmpo_compare_output_block
    import cmpo_pkg::*;
#(
    parameter int TICK_CYCLES = CMPO_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [CMPO_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [CMPO_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [63:0] count_value,
    input wire logic count_valid,
    input wire logic comm_fail,
    input wire logic [1:0] out_configured,
    output logic [1:0] hs_out,
    output logic irq
);
    typedef enum logic [1:0] {
        CMPO_IDLE,
        CMPO_ARMED,
        CMPO_HOLDING
    } cmpo_state_t;

    // byte-lane merge for writable registers
    function automatic logic [31:0] cmpo_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // fp equality: +0 equals -0, NaN matches nothing
    function automatic logic cmpo_fp_eq(input logic [63:0] a, input logic [63:0] b);
        logic a_nan;
        logic b_nan;
        a_nan = (a[62:52] == 11'h7ff) && (a[51:0] != 52'h0);
        b_nan = (b[62:52] == 11'h7ff) && (b[51:0] != 52'h0);
        if (a_nan || b_nan) begin
            return 1'b0;
        end
        if ((a[62:0] == 63'h0) && (b[62:0] == 63'h0)) begin
            return 1'b1;
        end
        return a == b;
    endfunction

    cmpo_reg_if rif ();

    cmpo_axil u_axil (
        .clk(clk),
        .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rif(rif.bus)
    );

    // software-written registers
    logic [1:0] ctrl_q;
    logic [7:0] channel_q;
    logic [63:0] thresh_q;
    logic [31:0] hold_q;
    logic [2:0] irq_mask_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_stat_d;

    // job state
    cmpo_state_t state_q;
    cmpo_state_t state_d;
    logic exec_prev_q;
    logic done_q;
    logic aborted_q;
    logic error_q;
    cmpo_fault_t fault_q;
    cmpo_fault_t fault_d;
    logic job_ch_q;
    logic [63:0] job_thresh_q;
    logic [31:0] job_hold_q;
    logic [1:0] hs_out_d;

    logic wr_ctrl;
    logic wr_chan;
    logic wr_tlo;
    logic wr_thi;
    logic wr_hold;
    logic wr_istat;
    logic wr_imask;
    logic exec_edge;
    logic abort_lvl;
    logic busy;
    logic chan_ok;
    logic hold_ok;
    logic cfg_ok;
    logic start_ok;
    logic start_fault;
    logic match;
    logic hold_expired;
    logic hold_start;
    logic job_stop;
    logic ev_done;
    logic ev_abort;
    logic ev_error;
    logic [31:0] status_word;

    assign wr_ctrl = rif.wr_en && (rif.wr_addr == CMPO_OFF_CTRL);
    assign wr_chan = rif.wr_en && (rif.wr_addr == CMPO_OFF_CHANNEL);
    assign wr_tlo = rif.wr_en && (rif.wr_addr == CMPO_OFF_THRESH_LO);
    assign wr_thi = rif.wr_en && (rif.wr_addr == CMPO_OFF_THRESH_HI);
    assign wr_hold = rif.wr_en && (rif.wr_addr == CMPO_OFF_HOLD);
    assign wr_istat = rif.wr_en && (rif.wr_addr == CMPO_OFF_IRQ_STAT);
    assign wr_imask = rif.wr_en && (rif.wr_addr == CMPO_OFF_IRQ_MASK);
    assign rif.wr_hit = wr_ctrl || wr_chan || wr_tlo || wr_thi || wr_hold || wr_istat || wr_imask
                        || (rif.wr_addr == CMPO_OFF_STATUS);

    assign busy = (state_q != CMPO_IDLE);
    // RULE1: edge-triggered start
    assign exec_edge = ctrl_q[CMPO_CTRL_EXEC_BIT] && !exec_prev_q;
    assign abort_lvl = ctrl_q[CMPO_CTRL_ABORT_BIT];
    // RULE4: channel range check
    assign chan_ok = (channel_q != 8'h00) && (channel_q <= CMPO_CHANNEL_MAX);
    // RULE6: zero hold is outside range
    assign hold_ok = (hold_q != 32'h0000_0000);
    // RULE12: terminal set up for channel
    assign cfg_ok = chan_ok && out_configured[channel_q == CMPO_CHANNEL_MAX];
    // a start under a held abort is ignored: it would end at once
    assign start_ok = exec_edge && !busy && !abort_lvl && chan_ok && hold_ok && cfg_ok;
    assign start_fault = exec_edge && !busy && !abort_lvl && !(chan_ok && hold_ok && cfg_ok);

    // RULE5: threshold equality test
    assign match = (state_q == CMPO_ARMED) && count_valid && cmpo_fp_eq(count_value, job_thresh_q);

    // link fault outranks abort, abort outranks a match
    assign ev_error = start_fault || (busy && comm_fail);
    assign ev_abort = busy && !comm_fail && abort_lvl;
    assign job_stop = busy && (comm_fail || abort_lvl);
    assign hold_start = match && !job_stop;
    assign ev_done = (state_q == CMPO_HOLDING) && hold_expired && !job_stop;

    cmpo_hold #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_hold (
        .clk(clk),
        .reset_n(reset_n),
        .start(hold_start),
        .stop(job_stop),
        .units(job_hold_q),
        .expired(hold_expired)
    );

    // RULE15: busy until one terminal report
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CMPO_IDLE: begin
                if (start_ok) begin
                    state_d = CMPO_ARMED;
                end
            end
            CMPO_ARMED: begin
                if (job_stop) begin
                    state_d = CMPO_IDLE;
                end else if (match) begin
                    state_d = CMPO_HOLDING;
                end
            end
            CMPO_HOLDING: begin
                // RULE9: back to idle, needs new edge
                if (job_stop || ev_done) begin
                    state_d = CMPO_IDLE;
                end
            end
        endcase
    end

    // RULE13: channel or hold invalid
    // RULE14: communication loss during job
    always_comb begin
        fault_d = fault_q;
        if (start_ok) begin
            fault_d = CMPO_FAULT_NONE;
        end else if (start_fault && !(chan_ok && hold_ok)) begin
            fault_d = CMPO_FAULT_PARAM;
        end else if (start_fault) begin
            fault_d = CMPO_FAULT_DO_CFG;
        end else if (busy && comm_fail) begin
            fault_d = CMPO_FAULT_COMM;
        end
    end

    // RULE7: drive selected port while holding
    assign hs_out_d = (state_d == CMPO_HOLDING) ? (job_ch_q ? 2'b10 : 2'b01) : 2'b00;

    // a new event wins over a clear in the same cycle
    assign irq_stat_d = (irq_stat_q & ~(wr_istat ? (rif.wr_data[2:0] & {3{rif.wr_strb[0]}}) : 3'b000))
                        | {ev_error, ev_abort, ev_done};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= 2'b00;
            channel_q <= CMPO_CHANNEL_RST;
            thresh_q <= CMPO_THRESH_RST;
            hold_q <= CMPO_HOLD_RST;
            irq_mask_q <= 3'b000;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= rif.wr_strb[0] ? rif.wr_data[1:0] : ctrl_q;
            end
            if (wr_chan) begin
                channel_q <= rif.wr_strb[0] ? rif.wr_data[7:0] : channel_q;
            end
            if (wr_tlo) begin
                thresh_q[31:0] <= cmpo_merge(thresh_q[31:0], rif.wr_data, rif.wr_strb);
            end
            if (wr_thi) begin
                thresh_q[63:32] <= cmpo_merge(thresh_q[63:32], rif.wr_data, rif.wr_strb);
            end
            if (wr_hold) begin
                hold_q <= cmpo_merge(hold_q, rif.wr_data, rif.wr_strb);
            end
            if (wr_imask) begin
                irq_mask_q <= rif.wr_strb[0] ? rif.wr_data[2:0] : irq_mask_q;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= CMPO_IDLE;
            exec_prev_q <= 1'b0;
            fault_q <= CMPO_FAULT_NONE;
            job_ch_q <= 1'b0;
            job_thresh_q <= CMPO_THRESH_RST;
            job_hold_q <= CMPO_HOLD_RST;
            hs_out <= 2'b00;
        end else begin
            state_q <= state_d;
            exec_prev_q <= ctrl_q[CMPO_CTRL_EXEC_BIT];
            fault_q <= fault_d;
            hs_out <= hs_out_d;
            // latched so later writes cannot disturb a running job
            if (start_ok) begin
                job_ch_q <= (channel_q == CMPO_CHANNEL_MAX);
                job_thresh_q <= thresh_q;
                job_hold_q <= hold_q;
            end
        end
    end

    // terminal flags stand until the next start attempt
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done_q <= 1'b0;
            aborted_q <= 1'b0;
            error_q <= 1'b0;
        end else if (exec_edge && !busy && !abort_lvl) begin
            done_q <= 1'b0;
            aborted_q <= 1'b0;
            // RULE10: refused start is an error
            error_q <= start_fault;
        end else begin
            // RULE8: done after hold expires
            if (ev_done) begin
                done_q <= 1'b1;
            end
            // RULE2: abort ends job
            // RULE3: acknowledge the abort
            if (ev_abort) begin
                aborted_q <= 1'b1;
            end
            if (ev_error) begin
                error_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_q <= 3'b000;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq <= |(irq_stat_d & irq_mask_q);
        end
    end

    // RULE11: code shown beside error
    assign status_word = {fault_q, 12'h000, error_q, aborted_q, busy, done_q};

    always_comb begin
        rif.rd_hit = 1'b1;
        rif.rd_data = 32'h0000_0000;
        unique case (rif.rd_addr)
            CMPO_OFF_CTRL: rif.rd_data = {30'h0000_0000, ctrl_q};
            CMPO_OFF_CHANNEL: rif.rd_data = {24'h00_0000, channel_q};
            CMPO_OFF_THRESH_LO: rif.rd_data = thresh_q[31:0];
            CMPO_OFF_THRESH_HI: rif.rd_data = thresh_q[63:32];
            CMPO_OFF_HOLD: rif.rd_data = hold_q;
            CMPO_OFF_STATUS: rif.rd_data = status_word;
            CMPO_OFF_IRQ_STAT: rif.rd_data = {29'h0000_0000, irq_stat_q};
            CMPO_OFF_IRQ_MASK: rif.rd_data = {29'h0000_0000, irq_mask_q};
            default: rif.rd_hit = 1'b0;
        endcase
    end
endmodule

// File: cmpo_chk.sv
// port-level assertions for the compare-match output unit
// assumes one clock; bound into every unit instance
`timescale 1ns/1ps
module cmpo_chk
    import cmpo_pkg::*;
#(
    parameter int TICK_CYCLES = CMPO_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic count_valid,
    input wire logic comm_fail,
    input wire logic [1:0] hs_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // one tick is four clocks in the bench
    sequence s_hold_run;
        hs_out[0] [*4];
    endsequence
    a_b_after_both: assert property (s_both_taken |-> ##[1:2] s_axi_bvalid)
        else $error("no write response");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read answer");
    a_aw_closed: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address taken");
    a_hs_one_port: assert property (hs_out != 2'h3)
        else $error("both outputs driven");
    a_hs_on_match: assert property ($rose(hs_out[0]) || $rose(hs_out[1]) |-> $past(count_valid))
        else $error("output without valid count");
    a_hs_min_hold: assert property (TICK_CYCLES >= 4 && $rose(hs_out[0]) && !comm_fail |-> s_hold_run)
        else $error("output hold too short");
    a_fail_drops: assert property (comm_fail |-> ##[1:2] hs_out == 2'h0)
        else $error("output kept after link fault");
endmodule
bind cmpo_compare_output_block cmpo_chk #(.TICK_CYCLES(TICK_CYCLES)) cmpo_chk_i (.*);

// File: cmpo_cnt_model.sv
// stand-in for the remote counter and its output terminal setup
// assumes it shares the unit's clock
`timescale 1ns/1ps
module cmpo_cnt_model (
    input wire logic clk,
    input wire logic run,
    input wire logic fail,
    input wire logic [1:0] cfg,
    output logic [63:0] count_value,
    output logic count_valid,
    output logic comm_fail,
    output logic [1:0] out_configured
);
    real n_q = 0.0;
    initial {count_value, count_valid, comm_fail, out_configured} = 68'h0;
    always @(posedge clk) begin
        n_q <= run ? n_q + 1.0 : 0.0;
        // a stopped counter toggles between its last count and its inverse
        count_value <= run ? $realtobits(n_q) : ~count_value;
        count_valid <= run;
        comm_fail <= fail;
        out_configured <= cfg;
    end
endmodule

// File: testbench.sv
// self-checking bench for the compare-match output unit
// assumes the hold tick is shortened to four clocks
`timescale 1ns/1ps
module testbench;
    import cmpo_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, run = 1'b0, fail = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] cfg = 2'h3, s_axi_bresp, s_axi_rresp, hs_out, out_configured;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic irq, count_valid, comm_fail;
    logic [63:0] count_value;
    int fail_count = 0;
    int total_checks = 0;
    cmpo_compare_output_block #(.TICK_CYCLES(4)) cmpo_compare_output_block_i (.*);
    cmpo_cnt_model cmpo_cnt_model_i (.*);
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = CMPO_RESP_OKAY);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check("bresp", s_axi_bresp, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r = CMPO_RESP_OKAY);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        check("rresp", s_axi_rresp, r);
    endtask
    task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        rd(a, st);
        check(what, st, exp);
    endtask
    // execute low then high: a fresh edge
    task automatic go;
        wr(CMPO_OFF_CTRL, 32'h0);
        wr(CMPO_OFF_CTRL, 32'h1);
        repeat (2) @(posedge clk);
    endtask
    task automatic wait_hs(input logic [1:0] m, output int n);
        n = 0;
        for (int i = 0; i < 60 && n == 0; i++) begin
            @(posedge clk);
            while (hs_out === m) begin
                n++;
                @(posedge clk);
            end
        end
    endtask
    task automatic t_reset;
        chk_rd("channel", CMPO_OFF_CHANNEL, 32'h1);
        chk_rd("thresh lo", CMPO_OFF_THRESH_LO, 32'h0);
        chk_rd("thresh hi", CMPO_OFF_THRESH_HI, 32'h0);
        chk_rd("hold", CMPO_OFF_HOLD, 32'h3e8);
        chk_rd("status", CMPO_OFF_STATUS, 32'h0);
        rd(8'h20, st, CMPO_RESP_SLVERR);
        check("unmapped rdata", st, 32'h0);
        wr(8'h24, 32'h1, CMPO_RESP_SLVERR);
    endtask
    task automatic t_match;
        int n;
        wr(CMPO_OFF_IRQ_MASK, 32'h1);
        wr(CMPO_OFF_HOLD, 32'h2);
        wr(CMPO_OFF_THRESH_HI, 32'h4034_0000);
        go;
        run <= 1'b1;
        wait_hs(2'h1, n);
        check("hold cycles", n, 64'h8);
        chk_rd("status done", CMPO_OFF_STATUS, 32'h1);
        check("irq done", irq, 1'b1);
        wr(CMPO_OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk);
        check("irq cleared", irq, 1'b0);
        run <= 1'b0;
        @(posedge clk);
        run <= 1'b1;
        wait_hs(2'h1, n);
        check("no refire", n, 64'h0);
        wr(CMPO_OFF_CHANNEL, 32'h2);
        run <= 1'b0;
        go;
        run <= 1'b1;
        wait_hs(2'h2, n);
        check("channel two hold", n, 64'h8);
    endtask
    task automatic t_abort;
        wr(CMPO_OFF_THRESH_HI, 32'hbff0_0000);
        go;
        chk_rd("status busy", CMPO_OFF_STATUS, 32'h2);
        wr(CMPO_OFF_CTRL, 32'h3);
        chk_rd("status aborted", CMPO_OFF_STATUS, 32'h4);
    endtask
    task automatic err_case(input logic [7:0] c, input logic [31:0] h, input logic [1:0] k, input logic f,
                            input logic [15:0] code);
        cfg <= k;
        wr(CMPO_OFF_CHANNEL, {24'h0, c});
        wr(CMPO_OFF_HOLD, h);
        fail <= f;
        go;
        chk_rd("status error", CMPO_OFF_STATUS, {code, 16'h8});
        fail <= 1'b0;
    endtask
    task automatic t_errors;
        wr(CMPO_OFF_IRQ_MASK, 32'h4);
        err_case(8'h3, 32'h1, 2'h3, 1'b0, CMPO_FAULT_PARAM);
        check("irq error", irq, 1'b1);
        wr(CMPO_OFF_IRQ_MASK, 32'h0);
        err_case(8'h1, 32'h0, 2'h3, 1'b0, CMPO_FAULT_PARAM);
        check("irq masked", irq, 1'b0);
        err_case(8'h1, 32'h1, 2'h2, 1'b0, CMPO_FAULT_DO_CFG);
        err_case(8'h2, 32'h1, 2'h3, 1'b1, CMPO_FAULT_COMM);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        t_match;
        t_abort;
        t_errors;
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report;
    end
endmodule
